// File: rtl/urx_pkg.sv
/*
 Package for the receive command reporter: field layout, encodings, reset
 values and the state type. Assumes a 60 MHz-class synchronous bus clock domain.
*/
package urx_pkg;
    localparam int LS_LO = 0;
    localparam int LS_HI = 1;
    localparam int VB_LO = 2;
    localparam int VB_HI = 3;
    localparam int RX_LO = 4;
    localparam int RX_HI = 5;
    localparam int ID_BIT = 6;
    localparam int ALT_BIT = 7;
    localparam logic [1:0] VB_BELOW_END = 2'h0;
    localparam logic [1:0] VB_END_VLD = 2'h1;
    localparam logic [1:0] VB_SESS_VLD = 2'h2;
    localparam logic [1:0] VB_ABOVE_VLD = 2'h3;
    localparam logic [1:0] RX_IDLE = 2'h0;
    localparam logic [1:0] RX_ACTIVE = 2'h1;
    localparam logic [1:0] RX_ACT_ERR = 2'h3;
    localparam logic [7:0] IDLE_BYTE = 8'h00;
    localparam logic [1:0] SYNC_RST = 2'h0;
    typedef enum logic [2:0] {ST_IDLE, ST_TURN_ON, ST_SEND, ST_TURN_OFF, ST_RECV} urx_state_type;
endpackage : urx_pkg

// File: rtl/urx_sync.sv
/*
 Two-flop synchroniser for a vector of pin levels.
 Assumes inputs are quasi-static relative to the clock.
*/
`timescale 1ns/1ps
module urx_sync #(parameter int W = 1)
(
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            q      <= '0;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : urx_sync

// File: rtl/urx_vbus_enc.sv
/*
 Encodes the three VBUS comparator outputs into the two-bit level code.
 Assumes comparators are already synchronised.
*/
`timescale 1ns/1ps
module urx_vbus_enc
(
    input  wire logic       sess_end,
    input  wire logic       sess_vld,
    input  wire logic       vbus_vld,
    output logic      [1:0] code
);
    // Highest threshold crossed wins; sess_end is redundant when above it
    assign code = vbus_vld ? urx_pkg::VB_ABOVE_VLD :
                  sess_vld ? urx_pkg::VB_SESS_VLD  :
                  sess_end ? urx_pkg::VB_BELOW_END : urx_pkg::VB_END_VLD;
endmodule : urx_vbus_enc

// File: rtl/urx_reporter.sv
/*
 Receive command reporter: decides when to send the status byte and drives
 DIR, NXT and the data bus as the device end of the link.
 Assumes pins arrive asynchronously and a datapath supplies receive events.
*/
`timescale 1ns/1ps
module urx_reporter
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       sync_mode,
    input  wire logic       startup_done,
    input  wire logic       mode_exit,
    input  wire logic       dp_se,
    input  wire logic       dm_se,
    input  wire logic       sess_end,
    input  wire logic       sess_vld,
    input  wire logic       vbus_vld,
    input  wire logic       id_pin,
    input  wire logic       alt_event,
    input  wire logic       rx_active,
    input  wire logic       rx_error,
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_byte,
    input  wire logic       tx_busy,
    input  wire logic       stp,
    output logic            dir,
    output logic            nxt,
    output logic      [7:0] data_o,
    output logic            data_oe
);
    logic [4:0] pins_s;
    logic [1:0] vb_code;
    logic [1:0] line_st;
    logic [1:0] line_prev_r;
    logic [1:0] vb_prev_r;
    logic       id_prev_r;
    logic       pend_r;
    logic       pend_nxt;
    logic       stp_seen_r;
    logic       start_done_r;
    logic       start_req;
    logic [2:0] warm_r;
    logic       armed;
    logic       trig;
    logic       rx_go;
    logic [1:0] rx_code;
    logic [7:0] status_byte;
    urx_pkg::urx_state_type state_r;
    urx_pkg::urx_state_type state_nxt;

    urx_sync #(.W(5)) u_sync
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        ({id_pin, vbus_vld, sess_vld, sess_end, dm_se}),
        .q        (pins_s)
    );

    logic [1:0] dp_s_r;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            dp_s_r <= urx_pkg::SYNC_RST;
        else
            dp_s_r <= {dp_s_r[0], dp_se};
    end

    urx_vbus_enc u_venc
    (
        .sess_end (pins_s[1]),
        .sess_vld (pins_s[2]),
        .vbus_vld (pins_s[3]),
        .code     (vb_code)
    );

    assign line_st = {pins_s[0], dp_s_r[1]};
    assign rx_code = !rx_active ? urx_pkg::RX_IDLE :
                     rx_error ? urx_pkg::RX_ACT_ERR : urx_pkg::RX_ACTIVE;
    // Byte is built from current levels at send time so it is never stale
    assign status_byte = {alt_event, pins_s[4], rx_code, vb_code, line_st};

    // Change detectors stay blind until the synchronisers hold real pin levels;
    // otherwise the fill after reset would report a comparator change
    assign armed = warm_r[2];
    // Line change counts only with DIR low; comparator changes always count
    assign trig = (armed && (line_st != line_prev_r) && !dir)
                || (armed && (vb_code != vb_prev_r || pins_s[4] != id_prev_r))
                || (tx_busy && stp)
                || (mode_exit && stp_seen_r)
                || start_req;
    assign start_req = startup_done && !start_done_r && !dir && !stp;
    // Multiple triggers merge into one pending flag, giving one byte
    assign pend_nxt = trig || (pend_r && !(state_r == urx_pkg::ST_SEND));
    assign rx_go = rx_active && !tx_busy;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_prev_r  <= 2'h0;
            vb_prev_r    <= 2'h0;
            id_prev_r    <= 1'b0;
            pend_r       <= 1'b0;
            stp_seen_r   <= 1'b0;
            start_done_r <= 1'b0;
            warm_r       <= 3'h0;
        end
        else
        begin
            line_prev_r  <= line_st;
            vb_prev_r    <= vb_code;
            id_prev_r    <= pins_s[4];
            pend_r       <= pend_nxt;
            stp_seen_r   <= stp ? 1'b1 : (mode_exit ? 1'b0 : stp_seen_r);
            start_done_r <= start_done_r | start_req;
            warm_r       <= {warm_r[1:0], 1'h1};
        end
    end

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            urx_pkg::ST_IDLE:
                if (sync_mode && (rx_go || pend_r) && !tx_busy)
                    state_nxt = urx_pkg::ST_TURN_ON;
            urx_pkg::ST_TURN_ON:
                state_nxt = rx_go ? urx_pkg::ST_RECV : urx_pkg::ST_SEND;
            urx_pkg::ST_SEND:
                state_nxt = rx_go ? urx_pkg::ST_RECV : urx_pkg::ST_TURN_OFF;
            urx_pkg::ST_RECV:
                if (!rx_go)
                    state_nxt = urx_pkg::ST_TURN_OFF;
            urx_pkg::ST_TURN_OFF:
                state_nxt = urx_pkg::ST_IDLE;
            default:
                state_nxt = urx_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= urx_pkg::ST_IDLE;
            dir     <= 1'b0;
            nxt     <= 1'b0;
            data_o  <= urx_pkg::IDLE_BYTE;
            data_oe <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            // DIR drops as the last driven cycle ends, so TURN_OFF is the turnaround;
            // holding DIR there would show the Link an undriven byte
            dir     <= (state_nxt != urx_pkg::ST_IDLE) && (state_nxt != urx_pkg::ST_TURN_OFF)
                       && sync_mode;
            // DIR and NXT together in the turnaround mark receive start
            nxt     <= (state_nxt == urx_pkg::ST_TURN_ON && rx_go) ||
                       (state_nxt == urx_pkg::ST_RECV && rx_valid);
            data_oe <= (state_nxt == urx_pkg::ST_SEND || state_nxt == urx_pkg::ST_RECV)
                       && sync_mode;
            data_o  <= (state_nxt == urx_pkg::ST_RECV && rx_valid) ? rx_byte
                     : status_byte;
        end
    end

    property p_turn;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(dir) |-> !data_oe;
    endproperty
    a_turn: assert property (p_turn) else $error("no turnaround after DIR rise");

    property p_sync;
        @(posedge core_clk) disable iff (!rst_n)
        data_oe |-> dir;
    endproperty
    a_sync: assert property (p_sync) else $error("bus driven with DIR low");

    property p_gap;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == urx_pkg::ST_RECV && !nxt && data_oe) |-> data_o[5:4] != urx_pkg::RX_IDLE;
    endproperty
    a_gap: assert property (p_gap) else $error("receive gap byte lacks rx code");

    property p_fall;
        @(posedge core_clk) disable iff (!rst_n)
        $fell(dir) |-> !data_oe;
    endproperty
    a_fall: assert property (p_fall) else $error("bus driven after DIR fall");

    property p_pend;
        @(posedge core_clk) disable iff (!rst_n)
        (pend_r && sync_mode && !tx_busy && !rx_go && state_r == urx_pkg::ST_IDLE)
            |-> ##2 data_oe;
    endproperty
    a_pend: assert property (p_pend) else $error("pending byte not sent");

    property p_tx;
        @(posedge core_clk) disable iff (!rst_n)
        (tx_busy && state_r == urx_pkg::ST_IDLE) |=> !dir;
    endproperty
    a_tx: assert property (p_tx) else $error("DIR taken during transmit");

    property p_rxs;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == urx_pkg::ST_TURN_ON && nxt) |-> dir;
    endproperty
    a_rxs: assert property (p_rxs) else $error("NXT without DIR at receive start");

    property p_one;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == urx_pkg::ST_SEND) |=> !pend_r || trig || $past(trig);
    endproperty
    a_one: assert property (p_one) else $error("merged triggers sent twice");

    // One status byte: owned and quiet, then driven, then released and quiet
    sequence s_turn_on;
        dir && !data_oe;
    endsequence

    sequence s_send;
        dir && data_oe && !nxt;
    endsequence

    sequence s_turn_off;
        !dir && !data_oe;
    endsequence

    property p_walk_in;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == urx_pkg::ST_TURN_ON && state_nxt == urx_pkg::ST_SEND)
            |-> s_turn_on ##1 s_send;
    endproperty
    a_walk_in: assert property (p_walk_in) else $error("byte not driven after turnaround");

    property p_walk_out;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == urx_pkg::ST_SEND && state_nxt == urx_pkg::ST_TURN_OFF)
            |-> s_send ##1 s_turn_off;
    endproperty
    a_walk_out: assert property (p_walk_out) else $error("DIR held with bus undriven");

    property p_start;
        @(posedge core_clk) disable iff (!rst_n)
        (start_req && sync_mode && !tx_busy && !rx_go) |-> ##[1:8] s_send;
    endproperty
    a_start: assert property (p_start) else $error("start-up byte missing");

    // Set wins over consumption, so a trigger in the SEND cycle is kept
    property p_trig;
        @(posedge core_clk) disable iff (!rst_n)
        trig |=> pend_r;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger lost");

    // Refused while transmitting, but never forgotten
    property p_stay;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == urx_pkg::ST_IDLE && tx_busy && pend_r) |=> pend_r;
    endproperty
    a_stay: assert property (p_stay) else $error("pending byte dropped in transmit");

    property p_fields;
        @(posedge core_clk) disable iff (!rst_n)
        s_send |-> data_o[urx_pkg::LS_HI:urx_pkg::LS_LO] == $past(line_st)
            && data_o[urx_pkg::VB_HI:urx_pkg::VB_LO] == $past(vb_code)
            && data_o[urx_pkg::RX_HI:urx_pkg::RX_LO] == $past(rx_code)
            && data_o[urx_pkg::ID_BIT] == $past(pins_s[4])
            && data_o[urx_pkg::ALT_BIT] == $past(alt_event);
    endproperty
    a_fields: assert property (p_fields) else $error("status field misplaced");

    property p_quiet;
        @(posedge core_clk) disable iff (!rst_n)
        (!sync_mode && state_r == urx_pkg::ST_IDLE) |=> !dir;
    endproperty
    a_quiet: assert property (p_quiet) else $error("DIR raised outside sync mode");

    property p_rxgo;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == urx_pkg::ST_IDLE && sync_mode && rx_go) |=> dir && nxt && !data_oe;
    endproperty
    a_rxgo: assert property (p_rxgo) else $error("receive start not flagged");

    property p_data;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == urx_pkg::ST_RECV && nxt) |-> data_oe && data_o == $past(rx_byte);
    endproperty
    a_data: assert property (p_data) else $error("received byte not on the bus");
endmodule : urx_reporter

// File: test/urx_link_model.sv
/*
 Link-side model: echoes stp, captures status bytes, counts turnaround slips.
 Assumes the reporter's registered bus outputs on the same clock.
*/
`timescale 1ns/1ps
module urx_link_model
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       dir,
    input  wire logic       nxt,
    input  wire logic [7:0] data_o,
    input  wire logic       data_oe,
    input  wire logic       stp_cmd,
    output logic            stp,
    output logic      [7:0] n_byte,
    output logic      [7:0] last_byte,
    output logic      [7:0] n_turn_err,
    output logic      [7:0] n_alt
);
    logic dir_r;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stp <= 1'b0;
            dir_r <= 1'b0;
            n_byte <= 8'h00;
            last_byte <= 8'h00;
            n_turn_err <= 8'h00;
            n_alt <= 8'h00;
        end
        else
        begin
            stp <= stp_cmd;
            dir_r <= dir;
            // Only bytes with nxt low are status bytes, not received data
            if (dir && data_oe && !nxt)
            begin
                n_byte <= n_byte + 8'h01;
                last_byte <= data_o;
                // Each alt flag seen in a status byte is counted in n_alt
                if (data_o[7])
                    n_alt <= n_alt + 8'h01;
            end
            // A held DIR with the bus undriven would hand the Link a garbage byte
            if (((dir != dir_r) && data_oe) || (dir && dir_r && !data_oe))
                n_turn_err <= n_turn_err + 8'h01;
        end
    end
endmodule : urx_link_model

// File: test/ulpi_rxcmd_status_reporter_bench.sv
/*
 Bench for the status reporter: scenario tasks, Link model on the far side.
 Assumes a 4 ns clock and a 3-cycle reset at start.
*/
`timescale 1ns/1ps
module ulpi_rxcmd_status_reporter_bench;
    logic core_clk = 0, rst_n = 0, sync_mode = 1, startup_done = 0, mode_exit = 0;
    logic dp_se = 1, dm_se = 0, sess_end = 0, sess_vld = 1, vbus_vld = 1, id_pin = 1;
    logic alt_event = 0, rx_active = 0, rx_error = 0, rx_valid = 0, tx_busy = 0, stp_cmd = 0;
    logic [7:0] rx_byte = 8'hA5;
    logic       dir, nxt, data_oe, stp;
    logic [7:0] data_o, n_byte, last_byte, n_turn_err, n_alt;
    int         n_fail = 0, check_count = 0, k;
    logic [2:0] vb_tab [4] = '{3'h4, 3'h0, 3'h2, 3'h1};

    always #2 core_clk = ~core_clk;

    urx_reporter dut_u (.core_clk(core_clk), .rst_n(rst_n), .sync_mode(sync_mode),
        .startup_done(startup_done), .mode_exit(mode_exit), .dp_se(dp_se), .dm_se(dm_se),
        .sess_end(sess_end), .sess_vld(sess_vld), .vbus_vld(vbus_vld), .id_pin(id_pin),
        .alt_event(alt_event), .rx_active(rx_active), .rx_error(rx_error),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_busy(tx_busy), .stp(stp),
        .dir(dir), .nxt(nxt), .data_o(data_o), .data_oe(data_oe));
    urx_link_model link_u (.core_clk(core_clk), .rst_n(rst_n), .dir(dir), .nxt(nxt),
        .data_o(data_o), .data_oe(data_oe), .stp_cmd(stp_cmd), .stp(stp),
        .n_byte(n_byte), .last_byte(last_byte), .n_turn_err(n_turn_err), .n_alt(n_alt));

    task summarize;
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    function automatic logic [7:0] exp_b();
        return {alt_event, id_pin, rx_active ? (rx_error ? 2'h3 : 2'h1) : 2'h0,
                vbus_vld ? 2'h3 : sess_vld ? 2'h2 : sess_end ? 2'h0 : 2'h1, dm_se, dp_se};
    endfunction : exp_b

    // Waits for a fresh byte, then lets merged triggers settle before judging
    task exp_byte;
        logic [7:0] n0;
        n0 = n_byte;
        k = 0;
        while (n_byte === n0 && k < 40)
        begin
            cyc(1);
            k++;
        end
        chk({7'h00, n_byte !== n0}, 8'h01);
        cyc(8);
        chk(last_byte, exp_b());
    endtask : exp_byte

    task no_byte(input int n);
        logic [7:0] n0;
        n0 = n_byte;
        cyc(n);
        chk(n_byte, n0);
    endtask : no_byte

    task t_line;
        for (int i = 0; i < 4; i++)
        begin
            {dm_se, dp_se} = i[1:0];
            exp_byte();
        end
    endtask : t_line

    task t_vbus;
        for (int i = 0; i < 4; i++)
        begin
            {sess_end, sess_vld, vbus_vld} = vb_tab[i];
            id_pin = i[0];
            exp_byte();
        end
    endtask : t_vbus

    task t_gate;
        alt_event = 1;
        dp_se = 0;
        exp_byte();
        chk(n_alt, 8'h01);
        alt_event = 0;
        sync_mode = 0;
        dm_se = 0;
        no_byte(30);
        sync_mode = 1;
        exp_byte();
        tx_busy = 1;
        stp_cmd = 1;
        cyc(1);
        stp_cmd = 0;
        no_byte(20);
        tx_busy = 0;
        exp_byte();
        stp_cmd = 1;
        cyc(1);
        stp_cmd = 0;
        cyc(2);
        mode_exit = 1;
        cyc(1);
        mode_exit = 0;
        exp_byte();
        mode_exit = 1;
        cyc(1);
        mode_exit = 0;
        no_byte(12);
    endtask : t_gate

    task t_rx;
        rx_active = 1;
        k = 0;
        while (dir !== 1'b1 && k < 20)
        begin
            cyc(1);
            k++;
        end
        chk({6'h00, dir, nxt}, 8'h03);
        exp_byte();
        rx_valid = 1;
        cyc(1);
        chk({7'h00, nxt}, 8'h01);
        chk(data_o, rx_byte);
        rx_valid = 0;
        cyc(1);
        chk({6'h00, nxt, data_oe}, 8'h01);
        rx_error = 1;
        exp_byte();
        rx_active = 0;
        rx_error = 0;
        cyc(12);
        chk({7'h00, dir}, 8'h00);
        chk(n_turn_err, 8'h00);
    endtask : t_rx

    initial
    begin
        cyc(3);
        rst_n = 1;
        cyc(4);
        chk({7'h00, dir}, 8'h00);
        startup_done = 1;
        exp_byte();
        t_line();
        t_vbus();
        t_gate();
        t_rx();
        summarize();
    end

    initial
    begin
        #20000;
        n_fail++;
        summarize();
    end
endmodule : ulpi_rxcmd_status_reporter_bench
